/* File: pin_change_pkg.sv */
package pin_change_pkg;
    // Pin and port geometry
    localparam int PORT_COUNT = 3;
    localparam int PORT_WIDTH = 8;
    localparam int PIN_COUNT = PORT_COUNT * PORT_WIDTH;

    // Register byte offsets, one aligned word per register
    localparam logic [7:0] RISE_ENABLE_OFFSET = 8'h00;
    localparam logic [7:0] FALL_ENABLE_OFFSET = 8'h04;
    localparam logic [7:0] FLAG_OFFSET = 8'h08;
    localparam logic [7:0] ENABLE_REG0_OFFSET = 8'h0C;
    localparam logic [7:0] REQUEST_REG0_OFFSET = 8'h10;
    localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h14;
    localparam logic [7:0] IRQ_CLEAR_OFFSET = 8'h18;
    localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h1C;
    localparam logic [7:0] SLEEP_CTRL_OFFSET = 8'h20;

    // Field positions
    localparam int CHANGE_IRQ_ENABLE_BIT = 4;
    localparam int CHANGE_IRQ_SUMMARY_BIT = 4;
    localparam int SLEEP_REQ_BIT = 0;
    localparam int EVT_EDGE_BIT = 0;
    localparam int EVT_WAKE_BIT = 1;
    localparam int EVENT_COUNT = 2;

    // Reset values
    localparam logic [31:0] REG_RESET = 32'h0000_0000;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } wr_req_t;

    typedef struct packed {
        logic [31:0] data;
        logic [1:0] resp;
    } rd_ans_t;
endpackage

/* File: pin_sync_edge.sv */
`timescale 1ns/100ps
module pin_sync_edge import pin_change_pkg::*; #(
    parameter int WIDTH = PIN_COUNT
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    // Pins and edges
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] rise_o,
    output logic [WIDTH-1:0] fall_o
);
    initial begin
        if (WIDTH < 1) $error("pin_sync_edge: WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
    logic [WIDTH-1:0] prev;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_stable;
    logic [WIDTH-1:0] next_prev;

    always_comb begin
        next_meta = meta;
        next_stable = stable;
        next_prev = prev;
        if (clk_en_i) begin
            next_meta = pin_i;
            next_stable = meta;
            next_prev = stable;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta <= '0;
            stable <= '0;
            prev <= '0;
        end else begin
            meta <= next_meta;
            stable <= next_stable;
            prev <= next_prev;
        end
    end

    // Edge is current sample against the previous one
    assign rise_o = stable & ~prev;
    assign fall_o = ~stable & prev;
endmodule // pin_sync_edge

/* File: axi_lite_slave.sv */
`timescale 1ns/100ps
module axi_lite_slave import pin_change_pkg::*; (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    // AXI4-Lite write
    input wire logic [31:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read
    input wire logic [31:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Register side
    output logic wr_stb_o,
    output wr_req_t wr_req_o,
    input wire logic wr_err_i,
    output logic rd_stb_o,
    output logic [31:0] rd_addr_o,
    input wire rd_ans_t rd_ans_i
);
    logic aw_held;
    logic w_held;
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    rd_ans_t rans;
    logic next_aw_held;
    logic next_w_held;
    logic [31:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_rvalid;
    rd_ans_t next_rans;

    assign s_axi_awready_o = clk_en_i && !aw_held && !bvalid;
    assign s_axi_wready_o = clk_en_i && !w_held && !bvalid;
    assign s_axi_arready_o = clk_en_i && !rvalid;
    assign s_axi_bvalid_o = bvalid;
    assign s_axi_bresp_o = bresp;
    assign s_axi_rvalid_o = rvalid;
    assign s_axi_rdata_o = rans.data;
    assign s_axi_rresp_o = rans.resp;

    logic aw_now;
    logic w_now;
    assign aw_now = aw_held || (s_axi_awvalid_i && s_axi_awready_o);
    assign w_now = w_held || (s_axi_wvalid_i && s_axi_wready_o);
    // Write commits once both halves are present
    assign wr_stb_o = clk_en_i && !bvalid && aw_now && w_now;
    assign wr_req_o.addr = aw_held ? aw_addr : s_axi_awaddr_i;
    assign wr_req_o.data = w_held ? w_data : s_axi_wdata_i;
    assign wr_req_o.strb = w_held ? w_strb : s_axi_wstrb_i;
    assign rd_stb_o = s_axi_arvalid_i && s_axi_arready_o;
    assign rd_addr_o = s_axi_araddr_i;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rans = rans;
        if (clk_en_i) begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                next_aw_held = 1'b1;
                next_aw_addr = s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                next_w_held = 1'b1;
                next_w_data = s_axi_wdata_i;
                next_w_strb = s_axi_wstrb_i;
            end
            if (wr_stb_o) begin
                next_aw_held = 1'b0;
                next_w_held = 1'b0;
                next_bvalid = 1'b1;
                next_bresp = wr_err_i ? RESP_SLVERR : RESP_OKAY;
            end else if (bvalid && s_axi_bready_i) begin
                next_bvalid = 1'b0;
            end
            if (rd_stb_o) begin
                next_rvalid = 1'b1;
                next_rans = rd_ans_i;
            end else if (rvalid && s_axi_rready_i) begin
                next_rvalid = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            rvalid <= 1'b0;
            rans <= '0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rans <= next_rans;
        end
    end
endmodule // axi_lite_slave

/* File: pin_change_interrupt.sv */
`timescale 1ns/100ps
module pin_change_interrupt import pin_change_pkg::*; #(
    parameter int PINS = PIN_COUNT
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    // Port pins
    input wire logic [PINS-1:0] pin_i,
    // Core side
    output logic change_irq_o,
    output logic wake_o,
    output logic sleeping_o,
    output logic irq_o,
    // AXI4-Lite write
    input wire logic [31:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read
    input wire logic [31:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);
    initial begin
        if (PINS < 1 || PINS > 32) $error("pin_change_interrupt: PINS must be 1 to 32");
    end

    // Byte-lane merge of a write into a word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) res[b*8 +: 8] = data[b*8 +: 8];
        end
        return res;
    endfunction

    logic [PINS-1:0] rise;
    logic [PINS-1:0] fall;
    logic wr_stb;
    wr_req_t wr_req;
    logic wr_err;
    logic rd_stb;
    logic [31:0] rd_addr;
    rd_ans_t rd_ans;

    pin_sync_edge #(
        .WIDTH(PINS)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .clk_en_i(clk_en_i),
        .pin_i(pin_i),
        .rise_o(rise),
        .fall_o(fall)
    );

    axi_lite_slave u_bus (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .clk_en_i(clk_en_i),
        .s_axi_awaddr_i(s_axi_awaddr_i),
        .s_axi_awvalid_i(s_axi_awvalid_i),
        .s_axi_awready_o(s_axi_awready_o),
        .s_axi_wdata_i(s_axi_wdata_i),
        .s_axi_wstrb_i(s_axi_wstrb_i),
        .s_axi_wvalid_i(s_axi_wvalid_i),
        .s_axi_wready_o(s_axi_wready_o),
        .s_axi_bresp_o(s_axi_bresp_o),
        .s_axi_bvalid_o(s_axi_bvalid_o),
        .s_axi_bready_i(s_axi_bready_i),
        .s_axi_araddr_i(s_axi_araddr_i),
        .s_axi_arvalid_i(s_axi_arvalid_i),
        .s_axi_arready_o(s_axi_arready_o),
        .s_axi_rdata_o(s_axi_rdata_o),
        .s_axi_rresp_o(s_axi_rresp_o),
        .s_axi_rvalid_o(s_axi_rvalid_o),
        .s_axi_rready_i(s_axi_rready_i),
        .wr_stb_o(wr_stb),
        .wr_req_o(wr_req),
        .wr_err_i(wr_err),
        .rd_stb_o(rd_stb),
        .rd_addr_o(rd_addr),
        .rd_ans_i(rd_ans)
    );

    // Register state
    logic [PINS-1:0] rise_detect_enable;
    logic [PINS-1:0] fall_detect_enable;
    logic [PINS-1:0] pin_change_flag;
    logic change_irq_enable;
    logic [EVENT_COUNT-1:0] irq_status;
    logic [EVENT_COUNT-1:0] irq_enable;
    logic sleeping;
    logic [PINS-1:0] next_rise_detect_enable;
    logic [PINS-1:0] next_fall_detect_enable;
    logic [PINS-1:0] next_pin_change_flag;
    logic next_change_irq_enable;
    logic [EVENT_COUNT-1:0] next_irq_status;
    logic [EVENT_COUNT-1:0] next_irq_enable;
    logic next_sleeping;

    logic [PINS-1:0] edge_hit;
    logic change_irq_summary;
    logic wake;
    logic [EVENT_COUNT-1:0] events;
    logic [7:0] wr_off;
    logic [7:0] rd_off;
    logic [31:0] wr_word;

    // Any pin, any combination, either or both edges
    assign edge_hit = (rise & rise_detect_enable) | (fall & fall_detect_enable);
    assign change_irq_summary = |pin_change_flag;
    assign change_irq_o = change_irq_enable && change_irq_summary;
    // Wake is combinational so the core sees it before its next instruction
    assign wake = sleeping && change_irq_o;
    assign wake_o = wake;
    assign sleeping_o = sleeping;
    assign events = {wake, |edge_hit};
    assign irq_o = |(irq_status & irq_enable);

    assign wr_off = wr_req.addr[7:0];
    assign rd_off = rd_addr[7:0];
    assign wr_err = !(wr_off inside {RISE_ENABLE_OFFSET, FALL_ENABLE_OFFSET, FLAG_OFFSET,
                                     ENABLE_REG0_OFFSET, REQUEST_REG0_OFFSET,
                                     IRQ_STATUS_OFFSET, IRQ_CLEAR_OFFSET,
                                     IRQ_ENABLE_OFFSET, SLEEP_CTRL_OFFSET})
                    || wr_req.addr[31:8] != '0;

    always_comb begin
        next_rise_detect_enable = rise_detect_enable;
        next_fall_detect_enable = fall_detect_enable;
        next_pin_change_flag = pin_change_flag;
        next_change_irq_enable = change_irq_enable;
        next_irq_status = irq_status;
        next_irq_enable = irq_enable;
        next_sleeping = sleeping;
        wr_word = '0;
        if (clk_en_i) begin
            if (wr_stb && !wr_err) begin
                unique case (wr_off)
                    RISE_ENABLE_OFFSET: begin
                        wr_word = merge(32'(rise_detect_enable), wr_req.data, wr_req.strb);
                        next_rise_detect_enable = wr_word[PINS-1:0];
                    end
                    FALL_ENABLE_OFFSET: begin
                        wr_word = merge(32'(fall_detect_enable), wr_req.data, wr_req.strb);
                        next_fall_detect_enable = wr_word[PINS-1:0];
                    end
                    FLAG_OFFSET: begin
                        // Zero clears; ones cannot set a flag
                        wr_word = merge(32'(pin_change_flag), wr_req.data, wr_req.strb);
                        next_pin_change_flag = pin_change_flag & wr_word[PINS-1:0];
                    end
                    ENABLE_REG0_OFFSET: begin
                        wr_word = merge(32'(change_irq_enable) << CHANGE_IRQ_ENABLE_BIT,
                                        wr_req.data, wr_req.strb);
                        next_change_irq_enable = wr_word[CHANGE_IRQ_ENABLE_BIT];
                    end
                    IRQ_CLEAR_OFFSET: begin
                        wr_word = merge(REG_RESET, wr_req.data, wr_req.strb);
                        next_irq_status = irq_status & ~wr_word[EVENT_COUNT-1:0];
                    end
                    IRQ_ENABLE_OFFSET: begin
                        wr_word = merge(32'(irq_enable), wr_req.data, wr_req.strb);
                        next_irq_enable = wr_word[EVENT_COUNT-1:0];
                    end
                    SLEEP_CTRL_OFFSET: begin
                        wr_word = merge(REG_RESET, wr_req.data, wr_req.strb);
                        next_sleeping = wr_word[SLEEP_REQ_BIT];
                    end
                    default: begin
                        // Read-only registers ignore writes
                        wr_word = '0;
                    end
                endcase
            end
            // New edges win over a clearing write
            next_pin_change_flag = next_pin_change_flag | edge_hit;
            next_irq_status = next_irq_status | events;
            if (wake) begin
                next_sleeping = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rise_detect_enable <= '0;
            fall_detect_enable <= '0;
            pin_change_flag <= '0;
            change_irq_enable <= 1'b0;
            irq_status <= '0;
            irq_enable <= '0;
            sleeping <= 1'b0;
        end else begin
            rise_detect_enable <= next_rise_detect_enable;
            fall_detect_enable <= next_fall_detect_enable;
            pin_change_flag <= next_pin_change_flag;
            change_irq_enable <= next_change_irq_enable;
            irq_status <= next_irq_status;
            irq_enable <= next_irq_enable;
            sleeping <= next_sleeping;
        end
    end

    always_comb begin
        rd_ans.resp = RESP_OKAY;
        rd_ans.data = REG_RESET;
        if (rd_addr[31:8] != '0) begin
            rd_ans.resp = RESP_SLVERR;
        end else begin
            unique case (rd_off)
                RISE_ENABLE_OFFSET: rd_ans.data = 32'(rise_detect_enable);
                FALL_ENABLE_OFFSET: rd_ans.data = 32'(fall_detect_enable);
                FLAG_OFFSET: rd_ans.data = 32'(pin_change_flag);
                ENABLE_REG0_OFFSET: rd_ans.data = 32'(change_irq_enable) << CHANGE_IRQ_ENABLE_BIT;
                REQUEST_REG0_OFFSET: rd_ans.data = 32'(change_irq_summary) << CHANGE_IRQ_SUMMARY_BIT;
                IRQ_STATUS_OFFSET: rd_ans.data = 32'(irq_status);
                IRQ_CLEAR_OFFSET: rd_ans.data = REG_RESET;
                IRQ_ENABLE_OFFSET: rd_ans.data = 32'(irq_enable);
                SLEEP_CTRL_OFFSET: rd_ans.data = 32'(sleeping);
                default: rd_ans.resp = RESP_SLVERR;
            endcase
        end
    end

    // Read strobe is unused here: reads have no side effects
    logic unused_rd;
    assign unused_rd = rd_stb;
endmodule // pin_change_interrupt

/* File: pin_change_interrupt_chk.sv */
`timescale 1ns/100ps
module pin_change_interrupt_chk import pin_change_pkg::*; #(
    parameter int PINS = PIN_COUNT
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    // Pins and core side
    input wire logic [PINS-1:0] pin_i,
    input wire logic change_irq_o,
    input wire logic wake_o,
    input wire logic sleeping_o,
    input wire logic irq_o,
    // Bus handshakes
    input wire logic s_axi_awready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence ar_taken;
        s_axi_arvalid_i && s_axi_arready_o && clk_en_i;
    endsequence
    // Synchroniser depth plus one sample of slack
    sequence pin_moved;
        $past(pin_i, 3) != $past(pin_i, 4) || $past(pin_i, 4) != $past(pin_i, 5);
    endsequence

    rd_answer_a: assert property (ar_taken |=> s_axi_rvalid_o)
        else $error("read answer missing");
    ar_block_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("address accepted during read answer");
    aw_block_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o)
        else $error("address accepted during write answer");
    r_once_a: assert property (s_axi_rvalid_o && s_axi_rready_i && clk_en_i |=> !s_axi_rvalid_o)
        else $error("read answer repeated");
    b_once_a: assert property (s_axi_bvalid_o && s_axi_bready_i && clk_en_i |=> !s_axi_bvalid_o)
        else $error("write answer repeated");
    irq_cause_a: assert property ($rose(change_irq_o) |-> pin_moved or s_axi_bvalid_o)
        else $error("change request without cause");
    flag_clear_a: assert property ($fell(change_irq_o) |-> s_axi_bvalid_o)
        else $error("change request dropped without write");
    irq_drop_a: assert property ($fell(irq_o) |-> s_axi_bvalid_o)
        else $error("interrupt dropped without write");
    wake_now_a: assert property (sleeping_o && change_irq_o |-> wake_o)
        else $error("no wake on pending change");
    wake_exit_a: assert property (wake_o && clk_en_i |=> !sleeping_o)
        else $error("sleep kept after wake");
    sleep_cause_a: assert property ($fell(sleeping_o) |-> $past(change_irq_o))
        else $error("sleep left before flag set");
endmodule // pin_change_interrupt_chk

bind pin_change_interrupt pin_change_interrupt_chk #(.PINS(PINS)) u_pin_change_interrupt_chk (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i),
    .pin_i(pin_i),
    .change_irq_o(change_irq_o),
    .wake_o(wake_o),
    .sleeping_o(sleeping_o),
    .irq_o(irq_o),
    .s_axi_awready_o(s_axi_awready_o),
    .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i),
    .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i)
);

/* File: pin_source.sv */
`timescale 1ns/100ps
module pin_source import pin_change_pkg::*; (
    // Clock
    input wire logic clk_sys_i,
    // Pins toward the block
    output logic [PIN_COUNT-1:0] pin_o
);
    // Levels held whole cycles; narrower pulses may be missed
    initial pin_o = {PIN_COUNT{1'b0}};
    task automatic drive(input logic [PIN_COUNT-1:0] v);
        @(posedge clk_sys_i);
        pin_o <= v;
    endtask
endmodule // pin_source

/* File: tb_pin_change_interrupt.sv */
`timescale 1ns/100ps
module tb_pin_change_interrupt import pin_change_pkg::*; ();
    localparam logic [31:0] MASTER = 32'h0000_0001 << CHANGE_IRQ_ENABLE_BIT;
    localparam logic [31:0] SUMMARY = 32'h0000_0001 << CHANGE_IRQ_SUMMARY_BIT;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic clk_en_i = 1'b1;
    logic [PIN_COUNT-1:0] pin_w;
    logic change_irq_o, wake_o, sleeping_o, irq_o;
    logic [31:0] awaddr = 32'h0000_0000, wdata = 32'h0000_0000, araddr = 32'h0000_0000;
    logic [31:0] rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    // Answer channels always accepted
    logic bready = 1'b1, rready = 1'b1;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    int err_count = 0;
    int n_checks = 0;
    int cycles = 0;

    always #10 clk_sys_i = ~clk_sys_i;

    pin_source u_pin_source (.clk_sys_i(clk_sys_i), .pin_o(pin_w));

    pin_change_interrupt u_pin_change_interrupt (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .pin_i(pin_w),
        .change_irq_o(change_irq_o), .wake_o(wake_o), .sleeping_o(sleeping_o), .irq_o(irq_o),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready)
    );

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= {24'h00_0000, a};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk_sys_i);
            if (awvalid && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk_sys_i); while (bvalid !== 1'b1);
        check("bresp", {30'h0, bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        araddr <= {24'h00_0000, a};
        arvalid <= 1'b1;
        do @(posedge clk_sys_i); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk_sys_i); while (rvalid !== 1'b1);
        check("rresp", {30'h0, rresp}, {30'h0, er});
        if (er == RESP_OKAY) check("rdata", rdata, exp);
    endtask

    task automatic t_reset();
        for (int i = 0; i <= 8; i++) begin
            rd(8'(i * 4), REG_RESET, RESP_OKAY);
        end
        rd(8'h40, REG_RESET, RESP_SLVERR);
        check("change_irq", {31'h0, change_irq_o}, 32'h0000_0000);
        $display("test reset done");
    endtask

    task automatic t_edges();
        wr(RISE_ENABLE_OFFSET, 32'h0080_0001, RESP_OKAY);
        wr(FALL_ENABLE_OFFSET, 32'h0080_0200, RESP_OKAY);
        rd(RISE_ENABLE_OFFSET, 32'h0080_0001, RESP_OKAY);
        // Pin 5 has no detector armed
        u_pin_source.drive(24'h80_0221);
        tick(6);
        rd(FLAG_OFFSET, 32'h0080_0001, RESP_OKAY);
        check("change_irq", {31'h0, change_irq_o}, 32'h0000_0000);
        rd(REQUEST_REG0_OFFSET, SUMMARY, RESP_OKAY);
        u_pin_source.drive(24'h00_0000);
        tick(6);
        rd(FLAG_OFFSET, 32'h0080_0201, RESP_OKAY);
        wr(ENABLE_REG0_OFFSET, MASTER, RESP_OKAY);
        check("change_irq", {31'h0, change_irq_o}, 32'h0000_0001);
        $display("test edges done");
    endtask

    task automatic t_clear();
        wr(FLAG_OFFSET, 32'h0080_0201 & ~32'h0000_0001, RESP_OKAY);
        rd(FLAG_OFFSET, 32'h0080_0200, RESP_OKAY);
        wr(FLAG_OFFSET, 32'h0000_0000, RESP_OKAY);
        rd(REQUEST_REG0_OFFSET, 32'h0000_0000, RESP_OKAY);
        check("change_irq", {31'h0, change_irq_o}, 32'h0000_0000);
        $display("test clear done");
    endtask

    task automatic t_race();
        // Last pass lands the edge on the clearing write itself
        for (int d = 0; d < 3; d++) begin
            u_pin_source.drive(d[0] ? 24'h00_0000 : 24'h80_0000);
            tick(d);
            wr(FLAG_OFFSET, 32'h0000_0000, RESP_OKAY);
            tick(4);
            rd(FLAG_OFFSET, 32'h0080_0000, RESP_OKAY);
            wr(FLAG_OFFSET, 32'h0000_0000, RESP_OKAY);
        end
        $display("test race done");
    endtask

    task automatic t_irq();
        rd(IRQ_STATUS_OFFSET, 32'h0000_0001, RESP_OKAY);
        check("irq", {31'h0, irq_o}, 32'h0000_0000);
        wr(IRQ_ENABLE_OFFSET, 32'h0000_0001, RESP_OKAY);
        check("irq", {31'h0, irq_o}, 32'h0000_0001);
        wr(IRQ_STATUS_OFFSET, 32'h0000_0000, RESP_OKAY);
        rd(IRQ_STATUS_OFFSET, 32'h0000_0001, RESP_OKAY);
        wr(IRQ_CLEAR_OFFSET, 32'h0000_0003, RESP_OKAY);
        rd(IRQ_CLEAR_OFFSET, 32'h0000_0000, RESP_OKAY);
        rd(IRQ_STATUS_OFFSET, 32'h0000_0000, RESP_OKAY);
        check("irq", {31'h0, irq_o}, 32'h0000_0000);
        wr(8'h44, 32'h0000_0001, RESP_SLVERR);
        $display("test irq done");
    endtask

    task automatic t_sleep();
        wr(ENABLE_REG0_OFFSET, 32'h0000_0000, RESP_OKAY);
        wr(SLEEP_CTRL_OFFSET, 32'h0000_0001, RESP_OKAY);
        check("sleeping", {31'h0, sleeping_o}, 32'h0000_0001);
        u_pin_source.drive(24'h00_0000);
        tick(6);
        check("sleeping", {31'h0, sleeping_o}, 32'h0000_0001);
        check("wake", {31'h0, wake_o}, 32'h0000_0000);
        wr(ENABLE_REG0_OFFSET, MASTER, RESP_OKAY);
        check("wake", {31'h0, wake_o}, 32'h0000_0001);
        tick(1);
        check("sleeping", {31'h0, sleeping_o}, 32'h0000_0000);
        rd(FLAG_OFFSET, 32'h0080_0000, RESP_OKAY);
        rd(IRQ_STATUS_OFFSET, 32'h0000_0003, RESP_OKAY);
        $display("test sleep done");
    endtask

    task automatic t_freeze();
        wr(IRQ_CLEAR_OFFSET, 32'h0000_0003, RESP_OKAY);
        // Pin moves while frozen; nothing may advance until enable returns
        clk_en_i <= 1'b0;
        u_pin_source.drive(24'h80_0000);
        tick(6);
        check("irq", {31'h0, irq_o}, 32'h0000_0000);
        clk_en_i <= 1'b1;
        tick(6);
        check("irq", {31'h0, irq_o}, 32'h0000_0001);
        rd(IRQ_STATUS_OFFSET, 32'h0000_0001, RESP_OKAY);
        $display("test freeze done");
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            conclude();
        end
    end

    initial begin
        repeat (16) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        t_reset();
        t_edges();
        t_clear();
        t_race();
        t_irq();
        t_sleep();
        t_freeze();
        conclude();
    end
endmodule // tb_pin_change_interrupt
